/* rts_pkg.sv */
package rts_pkg;
    // Input groups
    localparam int N_GTP = 30;
    localparam int N_FPS = 30;
    localparam int N_FPA = 15;
    localparam int N_HW = N_GTP + N_FPS + N_FPA;
    localparam int N_REQ = N_HW + 3;
    localparam int N_SSCLK = 4;
    localparam int N_LINK = 2;
    // Trigger word layout
    localparam int WORD_W = 16;
    localparam int TYPE_W = 8;
    localparam int SRC_W = 3;
    localparam int PS_W = 4;
    localparam int MARK_BIT = 15;
    localparam int SRC_LSB = 12;
    localparam int TYPE_LSB = 4;
    localparam logic [WORD_W-1:0] IDLE_WORD = 16'h0000;
    // Trigger source codes
    localparam logic [SRC_W-1:0] SRC_GTP = 3'h1;
    localparam logic [SRC_W-1:0] SRC_FPS = 3'h2;
    localparam logic [SRC_W-1:0] SRC_FPA = 3'h3;
    localparam logic [SRC_W-1:0] SRC_CAL = 3'h4;
    localparam logic [SRC_W-1:0] SRC_RND = 3'h5;
    localparam logic [SRC_W-1:0] SRC_PRE = 3'h6;
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int SLOT_DIV = 4;
    localparam int ALIGN_NS = 4;
    localparam int SYNC_CYC_RAW = (ALIGN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_CYC = (SYNC_CYC_RAW < 1) ? 1 : SYNC_CYC_RAW;
    localparam int FIFO_DEPTH = 8;
    // Counters and reset values
    localparam int CNT_W = 32;
    localparam int LAT_W = 16;
    localparam int PRE_W = 16;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;
endpackage

/* rts_stream_if.sv */
`timescale 1ns/1ps
interface rts_stream_if #(parameter int W = 16);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport producer(output valid, output data, input ready);
    modport consumer(input valid, input data, output ready);
endinterface

/* rts_fifo.sv */
`timescale 1ns/1ps
module rts_fifo #(
    parameter int W = 16,
    parameter int D = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Fill and drain sides
    rts_stream_if.consumer wr,
    rts_stream_if.producer rd
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    generate
        if (D < 2 || W < 1) begin : g_chk
            $error("rts_fifo needs D >= 2 and W >= 1");
        end
    endgenerate

    logic [W-1:0] mem_r [D];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic out_v_r, out_v_nxt;
    logic [W-1:0] out_d_r, out_d_nxt;
    logic do_wr, load;

    assign wr.ready = ((cnt_r + CW'(out_v_r)) != CW'(D));
    assign rd.valid = out_v_r;
    assign rd.data = out_d_r;

    always_comb begin
        do_wr = wr.valid & wr.ready;
        load = (cnt_r != '0) & (~out_v_r | rd.ready);
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        if (do_wr) begin
            wp_nxt = (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
        end
        if (load) begin
            rp_nxt = (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
        end
        cnt_nxt = cnt_r + CW'(do_wr) - CW'(load);
        out_v_nxt = load ? 1'b1 : (rd.ready ? 1'b0 : out_v_r);
        out_d_nxt = load ? mem_r[rp_r] : out_d_r;
    end

    always_ff @(posedge core_clk) begin
        if (do_wr) begin
            mem_r[wp_r] <= wr.data;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            out_v_r <= 1'b0;
            out_d_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            out_v_r <= out_v_nxt;
            out_d_r <= out_d_nxt;
        end
    end
endmodule

/* rts_top.sv */
// Contract
// - Take thirty processor primitives plus two clocks
// - Take thirty panel sync, fifteen async inputs
// - Prescale each input before forming events
// - Generate calibration, random and preset-count triggers
// - Event word carries type and source fields
// - Busy or inhibit suppresses events, runs dead counter
// - One sixteen-bit word per quarter-rate slot
// - Select system clock source, oscillator or external
// - Sync pulse aligned to word slot boundary
// - Front-end busy stops readout triggers
// - Inhibit input blocks every acquisition trigger
// - Links send trigger, clock, sync; receive ack, busy
// - Fourth lane loops back, measures fibre latency
// - Optional backplane pulse mode output
// - Collided or blocked triggers are counted lost
`timescale 1ns/1ps
module rts_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Trigger inputs
    input wire logic [rts_pkg::N_GTP-1:0] gtp_trig,
    input wire logic [1:0] gtp_ssclk,
    input wire logic [rts_pkg::N_FPS-1:0] fp_sync_trig,
    input wire logic [1:0] fp_ssclk,
    input wire logic [rts_pkg::N_FPA-1:0] fp_async_trig,
    // Prescale factors per group
    input wire logic [rts_pkg::PS_W-1:0] ps_gtp,
    input wire logic [rts_pkg::PS_W-1:0] ps_fps,
    input wire logic [rts_pkg::PS_W-1:0] ps_fpa,
    // Internal trigger sources
    input wire logic cal_cmd,
    input wire logic random_en,
    input wire logic [7:0] random_thresh,
    input wire logic preset_en,
    input wire logic preset_start,
    input wire logic [rts_pkg::PRE_W-1:0] preset_num,
    // Front-end status
    input wire logic fe_busy,
    input wire logic inhibit,
    input wire logic [rts_pkg::N_LINK-1:0] link_busy,
    input wire logic [rts_pkg::N_LINK-1:0] link_ack,
    // Clock select, sync and pulse mode
    input wire logic ext_clk_sel,
    output logic clk_sel,
    input wire logic sync_req,
    output logic sync_out,
    input wire logic pulse_mode,
    output logic bp_trig_pulse,
    // Serial trigger word stream
    input wire logic ser_hold,
    output logic [3:0] ser_data,
    output logic ser_frame,
    // Direct optical links
    output logic [rts_pkg::N_LINK-1:0] link_tx_trig,
    output logic [rts_pkg::N_LINK-1:0] link_tx_clk,
    output logic [rts_pkg::N_LINK-1:0] link_tx_sync,
    output logic [rts_pkg::N_LINK-1:0] ack_seen,
    // Latency lane
    input wire logic lat_start,
    output logic lat_tx,
    input wire logic lat_rx,
    output logic [rts_pkg::LAT_W-1:0] lat_value,
    output logic lat_valid,
    // Status and counters
    output logic [rts_pkg::N_SSCLK-1:0] ssclk_act,
    output logic [rts_pkg::CNT_W-1:0] dead_cnt,
    output logic [rts_pkg::CNT_W-1:0] lost_cnt,
    output logic [rts_pkg::CNT_W-1:0] event_cnt,
    output logic lost_pulse
);
    localparam int NH = rts_pkg::N_HW;
    localparam int NR = rts_pkg::N_REQ;
    localparam int NS = 2 + rts_pkg::N_LINK * 2 + 1 + rts_pkg::N_SSCLK;

    typedef enum logic [1:0] {LAT_IDLE, LAT_WAIT, LAT_DONE} rts_lat_t;

    function automatic logic [7:0] rts_first(input logic [NR-1:0] v);
        logic [7:0] idx;
        idx = '0;
        for (int i = NR - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 8'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic rts_multi(input logic [NR-1:0] v);
        return |(v & (v - 1'b1));
    endfunction

    // Pin synchronisers and edge delay
    logic [NH-1:0] hw_s1_r, hw_s2_r, hw_d_r;
    logic [NS-1:0] st_s1_r, st_s2_r, st_d_r;
    logic busy_s, inh_s, lat_rx_s;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hw_s1_r <= '0;
            hw_s2_r <= '0;
            hw_d_r <= '0;
            st_s1_r <= '0;
            st_s2_r <= '0;
            st_d_r <= '0;
        end else begin
            hw_s1_r <= {fp_async_trig, fp_sync_trig, gtp_trig};
            hw_s2_r <= hw_s1_r;
            hw_d_r <= hw_s2_r;
            st_s1_r <= {fp_ssclk, gtp_ssclk, lat_rx, link_ack, link_busy, inhibit, fe_busy};
            st_s2_r <= st_s1_r;
            st_d_r <= st_s2_r;
        end
    end
    assign busy_s = st_s2_r[0] | (|st_s2_r[2 +: rts_pkg::N_LINK]);
    assign inh_s = st_s2_r[1];
    assign lat_rx_s = st_s2_r[2 + 2 * rts_pkg::N_LINK];

    // Per-input prescalers
    logic [NH-1:0] hw_hit;
    genvar g;
    generate
        for (g = 0; g < NH; g++) begin : g_ps
            logic [rts_pkg::PS_W-1:0] cnt_r, cnt_nxt, fac;
            logic edge_det;
            always_comb begin
                fac = (g < rts_pkg::N_GTP) ? ps_gtp : ((g < rts_pkg::N_GTP + rts_pkg::N_FPS) ? ps_fps : ps_fpa);
                edge_det = hw_s2_r[g] & ~hw_d_r[g];
                hw_hit[g] = edge_det & (cnt_r == fac);
                cnt_nxt = cnt_r;
                if (edge_det) begin
                    cnt_nxt = (cnt_r == fac) ? '0 : cnt_r + 1'b1;
                end
            end
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    cnt_r <= '0;
                end else begin
                    cnt_r <= cnt_nxt;
                end
            end
        end
    endgenerate

    // Word slot divider and internal sources
    logic [1:0] div_r, div_nxt;
    logic slot_en, suppress, rnd_req, pre_req, cal_req, clk_tog_r, clk_tog_nxt;
    logic [15:0] lfsr_r, lfsr_nxt;
    logic [rts_pkg::PRE_W-1:0] pre_left_r, pre_left_nxt;
    assign slot_en = (div_r == 2'(rts_pkg::SLOT_DIV - 1));
    assign suppress = busy_s | inh_s;
    assign cal_req = cal_cmd;
    assign rnd_req = random_en & slot_en & (lfsr_r[7:0] < random_thresh);
    assign pre_req = preset_en & slot_en & (pre_left_r != '0);
    always_comb begin
        div_nxt = slot_en ? '0 : div_r + 1'b1;
        clk_tog_nxt = slot_en ? ~clk_tog_r : clk_tog_r;
        lfsr_nxt = lfsr_r[0] ? ((lfsr_r >> 1) ^ rts_pkg::LFSR_TAPS) : (lfsr_r >> 1);
        pre_left_nxt = pre_left_r;
        if (preset_start) begin
            pre_left_nxt = preset_num;
        end else if (pre_req) begin
            pre_left_nxt = pre_left_r - 1'b1;
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div_r <= '0;
            clk_tog_r <= 1'b0;
            lfsr_r <= rts_pkg::LFSR_SEED;
            pre_left_r <= '0;
        end else begin
            div_r <= div_nxt;
            clk_tog_r <= clk_tog_nxt;
            lfsr_r <= lfsr_nxt;
            pre_left_r <= pre_left_nxt;
        end
    end

    // Slot accumulation and event decision
    rts_stream_if #(.W(rts_pkg::WORD_W)) wr_if();
    rts_stream_if #(.W(rts_pkg::WORD_W)) rd_if();
    logic [NR-1:0] req_vec;
    logic [7:0] cyc_idx;
    logic pend_r, pend_nxt, multi_r, multi_nxt, fin_pend, fin_multi, push, lost;
    logic [7:0] idx_r, idx_nxt, fin_idx;
    logic [1:0] ph_r, ph_nxt, fin_ph;
    logic [rts_pkg::SRC_W-1:0] fin_src;
    logic [rts_pkg::CNT_W-1:0] dead_r, dead_nxt, lost_r, lost_nxt, ev_r, ev_nxt;
    logic lost_p_r, bp_r, ev_p_r;
    assign req_vec = {pre_req, rnd_req, cal_req, hw_hit};
    assign cyc_idx = rts_first(req_vec);
    always_comb begin
        fin_pend = pend_r | (|req_vec);
        fin_multi = multi_r | rts_multi(req_vec) | (pend_r & (|req_vec));
        fin_idx = pend_r ? idx_r : cyc_idx;
        fin_ph = pend_r ? ph_r : div_r;
        if (fin_idx < 8'(rts_pkg::N_GTP)) begin
            fin_src = rts_pkg::SRC_GTP;
        end else if (fin_idx < 8'(rts_pkg::N_GTP + rts_pkg::N_FPS)) begin
            fin_src = rts_pkg::SRC_FPS;
        end else if (fin_idx < 8'(NH)) begin
            fin_src = rts_pkg::SRC_FPA;
        end else if (fin_idx == 8'(NH)) begin
            fin_src = rts_pkg::SRC_CAL;
        end else if (fin_idx == 8'(NH + 1)) begin
            fin_src = rts_pkg::SRC_RND;
        end else begin
            fin_src = rts_pkg::SRC_PRE;
        end
        push = slot_en & fin_pend & ~suppress & wr_if.ready;
        lost = slot_en & fin_pend & (suppress | ~wr_if.ready | fin_multi);
        wr_if.valid = push;
        wr_if.data = {1'b1, fin_src, fin_idx + 8'h01, 2'b00, fin_ph};
        pend_nxt = slot_en ? 1'b0 : fin_pend;
        multi_nxt = slot_en ? 1'b0 : fin_multi;
        idx_nxt = slot_en ? '0 : fin_idx;
        ph_nxt = slot_en ? '0 : fin_ph;
        dead_nxt = (slot_en & suppress) ? dead_r + 1'b1 : dead_r;
        lost_nxt = lost ? lost_r + 1'b1 : lost_r;
        ev_nxt = push ? ev_r + 1'b1 : ev_r;
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pend_r <= 1'b0;
            multi_r <= 1'b0;
            idx_r <= '0;
            ph_r <= '0;
            dead_r <= '0;
            lost_r <= '0;
            ev_r <= '0;
            lost_p_r <= 1'b0;
            bp_r <= 1'b0;
            ev_p_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
            multi_r <= multi_nxt;
            idx_r <= idx_nxt;
            ph_r <= ph_nxt;
            dead_r <= dead_nxt;
            lost_r <= lost_nxt;
            ev_r <= ev_nxt;
            lost_p_r <= lost;
            bp_r <= push & pulse_mode;
            ev_p_r <= push;
        end
    end

    rts_fifo #(.W(rts_pkg::WORD_W), .D(rts_pkg::FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .wr(wr_if),
        .rd(rd_if)
    );

    // Serializer: one word per slot, four bits per cycle
    logic [rts_pkg::WORD_W-1:0] sh_r, sh_nxt;
    logic frame_r, frame_nxt;
    logic [3:0] sd_r, sd_nxt;
    always_comb begin
        rd_if.ready = slot_en & ~ser_hold;
        frame_nxt = slot_en;
        if (slot_en) begin
            sh_nxt = (rd_if.valid & ~ser_hold) ? rd_if.data : rts_pkg::IDLE_WORD;
        end else begin
            sh_nxt = {sh_r[11:0], 4'h0};
        end
        sd_nxt = sh_nxt[15:12];
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sh_r <= rts_pkg::IDLE_WORD;
            frame_r <= 1'b0;
            sd_r <= '0;
        end else begin
            sh_r <= sh_nxt;
            frame_r <= frame_nxt;
            sd_r <= sd_nxt;
        end
    end

    // Sync, clock select and link status
    logic sync_pend_r, sync_pend_nxt, sync_r, sync_nxt, clk_sel_r;
    logic [rts_pkg::N_LINK-1:0] ack_r;
    logic [rts_pkg::N_SSCLK-1:0] ss_r;
    always_comb begin
        sync_nxt = sync_pend_r & slot_en;
        sync_pend_nxt = sync_req | (sync_pend_r & ~slot_en);
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync_pend_r <= 1'b0;
            sync_r <= 1'b0;
            clk_sel_r <= 1'b0;
            ack_r <= '0;
            ss_r <= '0;
        end else begin
            sync_pend_r <= sync_pend_nxt;
            sync_r <= sync_nxt;
            clk_sel_r <= ext_clk_sel;
            ack_r <= st_s2_r[2 + rts_pkg::N_LINK +: rts_pkg::N_LINK] & ~st_d_r[2 + rts_pkg::N_LINK +: rts_pkg::N_LINK];
            ss_r <= st_s2_r[NS-1 -: rts_pkg::N_SSCLK] ^ st_d_r[NS-1 -: rts_pkg::N_SSCLK];
        end
    end

    // Fibre latency measurement on the fourth lane
    rts_lat_t lat_st_r, lat_st_nxt;
    logic [rts_pkg::LAT_W-1:0] lat_cnt_r, lat_cnt_nxt;
    logic lat_tx_r, lat_tx_nxt, lat_rx_rise;
    assign lat_rx_rise = lat_rx_s & ~st_d_r[2 + 2 * rts_pkg::N_LINK];
    always_comb begin
        lat_st_nxt = lat_st_r;
        lat_cnt_nxt = lat_cnt_r;
        lat_tx_nxt = 1'b0;
        case (lat_st_r)
            LAT_IDLE, LAT_DONE: begin
                if (lat_start) begin
                    lat_st_nxt = LAT_WAIT;
                    lat_cnt_nxt = '0;
                    lat_tx_nxt = 1'b1;
                end
            end
            LAT_WAIT: begin
                if (lat_rx_rise || (&lat_cnt_r)) begin
                    lat_st_nxt = LAT_DONE;
                end else begin
                    lat_cnt_nxt = lat_cnt_r + 1'b1;
                end
            end
            default: begin
                lat_st_nxt = LAT_IDLE;
            end
        endcase
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lat_st_r <= LAT_IDLE;
            lat_cnt_r <= '0;
            lat_tx_r <= 1'b0;
        end else begin
            lat_st_r <= lat_st_nxt;
            lat_cnt_r <= lat_cnt_nxt;
            lat_tx_r <= lat_tx_nxt;
        end
    end

    // Outputs
    assign clk_sel = clk_sel_r;
    assign sync_out = sync_r;
    assign bp_trig_pulse = bp_r;
    assign ser_data = sd_r;
    assign ser_frame = frame_r;
    assign link_tx_trig = {rts_pkg::N_LINK{ev_p_r}};
    assign link_tx_clk = {rts_pkg::N_LINK{clk_tog_r}};
    assign link_tx_sync = {rts_pkg::N_LINK{sync_r}};
    assign ack_seen = ack_r;
    assign lat_tx = lat_tx_r;
    assign lat_value = lat_cnt_r;
    assign lat_valid = (lat_st_r == LAT_DONE);
    assign ssclk_act = ss_r;
    assign dead_cnt = dead_r;
    assign lost_cnt = lost_r;
    assign event_cnt = ev_r;
    assign lost_pulse = lost_p_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_slot_period: assert property (slot_en |=> !slot_en [*3] ##1 slot_en)
        else $error("word slot period wrong");
    a_frame_period: assert property (ser_frame |=> !ser_frame [*3] ##1 ser_frame)
        else $error("serial frame spacing wrong");
    a_busy_blocks: assert property (slot_en && busy_s |-> !wr_if.valid)
        else $error("event pushed while busy");
    a_inhibit_blocks: assert property (inh_s |-> !wr_if.valid ##1 !ev_p_r)
        else $error("event pushed while inhibited");
    a_dead_counts: assert property (slot_en && suppress |=> dead_cnt == $past(dead_cnt) + 1'b1)
        else $error("dead counter did not advance");
    a_dead_holds: assert property (!(slot_en && suppress) |=> dead_cnt == $past(dead_cnt))
        else $error("dead counter moved when live");
    a_lost_count: assert property (slot_en && fin_pend && suppress |=> lost_pulse && lost_cnt == $past(lost_cnt) + 1'b1)
        else $error("lost trigger not counted");
    a_preset_stop: assert property (pre_left_r == '0 && !preset_start |=> !pre_req)
        else $error("preset source ran past its count");
    a_sync_slot: assert property (sync_out |-> $past(slot_en))
        else $error("sync off slot boundary");
    a_pulse_mode: assert property (bp_trig_pulse |-> $past(pulse_mode) && ev_p_r)
        else $error("pulse without event or mode");
    a_word_source: assert property (wr_if.valid && wr_if.data[11:4] == 8'(NH + 1) |-> wr_if.data[14:12] == rts_pkg::SRC_CAL)
        else $error("source field wrong");

    c_event: cover property (wr_if.valid ##[1:8] ser_frame);
    c_lost_multi: cover property (slot_en && fin_multi && !suppress);
    c_latency: cover property (lat_tx ##[1:50] lat_valid);
endmodule

/* rts_rx_model.sv */
`timescale 1ns/1ps
module rts_rx_model #(
    parameter int LOOP_DLY = 6
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Commands from bench
    input wire logic hold_cmd,
    input wire logic [1:0] busy_cmd,
    // Serial word stream
    input wire logic [3:0] ser_data,
    input wire logic ser_frame,
    output logic ser_hold,
    output logic [15:0] word,
    output logic word_valid,
    // Link and latency lane
    input wire logic [1:0] link_tx_trig,
    output logic [1:0] link_busy,
    output logic [1:0] link_ack,
    input wire logic lat_tx,
    output logic lat_rx
);
    logic [11:0] sh;
    logic [1:0] n;
    logic [1:0] ack_p0, ack_p1;
    logic [LOOP_DLY-1:0] loop_r;
    assign lat_rx = loop_r[LOOP_DLY-1];
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sh <= 12'h000;
            n <= 2'd0;
            word <= 16'h0000;
            word_valid <= 1'b0;
            ser_hold <= 1'b0;
            link_busy <= 2'b00;
            ack_p0 <= 2'b00;
            ack_p1 <= 2'b00;
            link_ack <= 2'b00;
            loop_r <= '0;
        end else begin
            ser_hold <= hold_cmd;
            link_busy <= busy_cmd;
            ack_p0 <= link_tx_trig;
            ack_p1 <= ack_p0;
            link_ack <= ack_p1;
            loop_r <= {loop_r[LOOP_DLY-2:0], lat_tx};
            word_valid <= 1'b0;
            if (ser_frame) begin
                sh <= {8'h00, ser_data};
                n <= 2'd1;
            end else if (n != 2'd0) begin
                sh <= {sh[7:0], ser_data};
                n <= n + 2'd1;
                if (n == 2'd3) begin
                    word <= {sh, ser_data};
                    word_valid <= sh[11];
                end
            end
        end
    end
endmodule

/* readout_trigger_supervisor_test.sv */
`timescale 1ns/1ps
module readout_trigger_supervisor_test;
    logic core_clk = 0, nrst = 0;
    logic [74:0] hw_r = '0;
    logic [3:0] ssclk_r = 4'h0;
    logic [3:0] ps_gtp = 4'h0;
    logic cal_cmd = 0, random_en = 0, preset_en = 0, preset_start = 0, fe_busy = 0, inhibit = 0;
    logic ext_clk_sel = 0, sync_req = 0, pulse_mode = 1, lat_start = 0, hold_cmd = 0, rnd_mode = 0, pclk = 0;
    logic [15:0] preset_num = 16'h0000;
    logic [1:0] busy_cmd = 2'b00;
    logic clk_sel, sync_out, bp_trig_pulse, ser_hold, ser_frame, lat_tx, lat_rx, lat_valid, lost_pulse, wv;
    logic [3:0] ser_data, ssclk_act;
    logic [1:0] link_busy, link_ack, link_tx_trig, link_tx_clk, link_tx_sync, ack_seen;
    logic [15:0] lat_value, w;
    logic [31:0] dead_cnt, lost_cnt, event_cnt, l0, d0, e0, rs = 32'd3013;
    logic [15:0] q[$];
    int err_count = 0, n_tests = 0, n_bp = 0, n_ltx = 0, n_ack = 0, n_sync = 0, cyc_n = 0;
    always #10 core_clk = ~core_clk;
    rts_top rts_top_inst (.core_clk(core_clk), .nrst(nrst), .gtp_trig(hw_r[29:0]), .gtp_ssclk(ssclk_r[1:0]),
        .fp_sync_trig(hw_r[59:30]), .fp_ssclk(ssclk_r[3:2]), .fp_async_trig(hw_r[74:60]), .ps_gtp(ps_gtp),
        .ps_fps(4'h0), .ps_fpa(4'h0), .cal_cmd(cal_cmd), .random_en(random_en), .random_thresh(8'hFF),
        .preset_en(preset_en), .preset_start(preset_start), .preset_num(preset_num), .fe_busy(fe_busy),
        .inhibit(inhibit), .link_busy(link_busy), .link_ack(link_ack), .ext_clk_sel(ext_clk_sel),
        .clk_sel(clk_sel), .sync_req(sync_req), .sync_out(sync_out), .pulse_mode(pulse_mode),
        .bp_trig_pulse(bp_trig_pulse), .ser_hold(ser_hold), .ser_data(ser_data), .ser_frame(ser_frame),
        .link_tx_trig(link_tx_trig), .link_tx_clk(link_tx_clk), .link_tx_sync(link_tx_sync),
        .ack_seen(ack_seen), .lat_start(lat_start), .lat_tx(lat_tx), .lat_rx(lat_rx), .lat_value(lat_value),
        .lat_valid(lat_valid), .ssclk_act(ssclk_act), .dead_cnt(dead_cnt), .lost_cnt(lost_cnt),
        .event_cnt(event_cnt), .lost_pulse(lost_pulse));
    rts_rx_model #(.LOOP_DLY(6)) rts_rx_model_inst (.core_clk(core_clk), .nrst(nrst), .hold_cmd(hold_cmd),
        .busy_cmd(busy_cmd), .ser_data(ser_data), .ser_frame(ser_frame), .ser_hold(ser_hold), .word(w),
        .word_valid(wv), .link_tx_trig(link_tx_trig), .link_busy(link_busy), .link_ack(link_ack),
        .lat_tx(lat_tx), .lat_rx(lat_rx));
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    function automatic logic [15:0] ew(logic [2:0] src, int idx);
        return {1'b1, src, 8'(idx + 1), 4'h0};
    endfunction
    task automatic check(string nm, logic [31:0] s, logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic endt(string nm);
        $display("test %s done", nm);
    endtask
    task automatic snap();
        l0 = lost_cnt;
        d0 = dead_cnt;
        e0 = event_cnt;
    endtask
    task automatic fire(int idx, bit want);
        hw_r[idx] <= 1'b1;
        cyc(3);
        hw_r[idx] <= 1'b0;
        if (want) q.push_back(ew(idx < 30 ? rts_pkg::SRC_GTP : idx < 60 ? rts_pkg::SRC_FPS : rts_pkg::SRC_FPA, idx));
        cyc(24);
    endtask
    task automatic cal(bit want);
        cal_cmd <= 1'b1;
        cyc(1);
        cal_cmd <= 1'b0;
        if (want) q.push_back(ew(rts_pkg::SRC_CAL, 75));
        cyc(3);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc_n++;
        n_bp += bp_trig_pulse === 1'b1;
        n_ltx += link_tx_trig[0] === 1'b1;
        n_ack += ack_seen[0] === 1'b1;
        n_sync += sync_out === 1'b1;
        if (sync_out === 1'b1) begin
            check("sync_frame", ser_frame, 1'b1);
            check("link_sync", link_tx_sync, 2'b11);
        end
        if (wv === 1'b1) begin
            if (rnd_mode) check("rnd_src", w[14:12], rts_pkg::SRC_RND);
            else if (q.size() == 0) check("unexpected_word", w, 16'h0000);
            else check("word", w & 16'hFFFC, q.pop_front());
        end
        if (ser_frame === 1'b1) check("link_clk", link_tx_clk, {2{~pclk}});
        pclk = link_tx_clk[0];
        if (cyc_n == 6000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        int idx;
        logic got;
        cyc(20);
        nrst <= 1'b1;
        cyc(4);
        foreach (hw_r[i]) if (i inside {0, 29, 30, 59, 60, 74}) fire(i, 1);
        repeat (6) begin
            idx = int'(xs() % 75);
            fire(idx, 1);
        end
        cal(1);
        cyc(24);
        endt("sources");
        ps_gtp <= 4'h1;
        fire(5, 0);
        fire(5, 1);
        fire(5, 0);
        ps_gtp <= 4'h0;
        endt("prescale");
        snap();
        hw_r <= 75'h88;
        cyc(3);
        hw_r <= '0;
        q.push_back(ew(rts_pkg::SRC_GTP, 3));
        cyc(24);
        check("collide_lost", lost_cnt - l0, 32'h0000_0001);
        endt("collision");
        for (int m = 0; m < 3; m++) begin
            fe_busy <= (m == 0);
            inhibit <= (m == 1);
            busy_cmd <= (m == 2) ? 2'b10 : 2'b00;
            cyc(6);
            snap();
            cal(0);
            cyc(14);
            check("busy_event", event_cnt, e0);
            check("busy_lost", lost_cnt - l0, 32'h0000_0001);
            check("dead_runs", 32'(dead_cnt - d0 >= 32'h0000_0003), 32'h0000_0001);
            fe_busy <= 1'b0;
            inhibit <= 1'b0;
            busy_cmd <= 2'b00;
            cyc(8);
            snap();
            cyc(12);
            check("dead_held", dead_cnt, d0);
        end
        endt("busy");
        snap();
        preset_num <= 16'h0003;
        preset_en <= 1'b1;
        preset_start <= 1'b1;
        cyc(1);
        preset_start <= 1'b0;
        repeat (3) q.push_back(ew(rts_pkg::SRC_PRE, 77));
        cyc(48);
        preset_en <= 1'b0;
        check("preset_count", event_cnt - e0, 32'h0000_0003);
        endt("preset");
        hold_cmd <= 1'b1;
        cyc(4);
        snap();
        for (int k = 0; k < 12; k++) cal(k < rts_pkg::FIFO_DEPTH);
        cyc(8);
        check("fifo_full_lost", lost_cnt - l0, 32'h0000_0004);
        hold_cmd <= 1'b0;
        cyc(60);
        check("drained", q.size(), 0);
        endt("fifo");
        snap();
        rnd_mode <= 1'b1;
        random_en <= 1'b1;
        cyc(40);
        random_en <= 1'b0;
        cyc(40);
        rnd_mode <= 1'b0;
        check("random_ran", 32'(event_cnt != e0), 32'h0000_0001);
        endt("random");
        idx = n_sync;
        sync_req <= 1'b1;
        cyc(1);
        sync_req <= 1'b0;
        cyc(10);
        check("sync_once", n_sync - idx, 1);
        ext_clk_sel <= 1'b1;
        cyc(3);
        check("clk_sel", clk_sel, 1'b1);
        ext_clk_sel <= 1'b0;
        for (int b = 0; b < 4; b++) begin
            got = 1'b0;
            ssclk_r[b] <= ~ssclk_r[b];
            repeat (8) begin
                cyc(1);
                if (ssclk_act[b] === 1'b1) got = 1'b1;
            end
            check("ssclk_act", got, 1'b1);
        end
        lat_start <= 1'b1;
        cyc(1);
        lat_start <= 1'b0;
        repeat (60) if (lat_valid !== 1'b1) cyc(1);
        check("lat_valid", lat_valid, 1'b1);
        check("lat_range", 32'(lat_value >= 16'h0006 && lat_value <= 16'h000C), 32'h0000_0001);
        endt("sync_clock_latency");
        check("bp_pulses", n_bp, event_cnt);
        check("link_trig", n_ltx, event_cnt);
        check("link_ack", n_ack, n_ltx);
        final_report();
    end
endmodule
